// ---- hw/ilr_pkg.sv ----
// shared constants, field layouts and carrier types for the legacy route block
package ilr_pkg;

  // sizes
  localparam int unsigned ILR_NUM_IRQ = 32;
  localparam int unsigned ILR_NUM_IRQ_SMALL = 24;
  localparam int unsigned ILR_SB_WIDTH = 8;
  localparam int unsigned ILR_IDX_W = 8;
  localparam int unsigned ILR_SEL_W = 5;

  // register indices of the direct memory mapped space
  localparam logic [7:0] ILR_IDX_ENTRY_LOW_BASE = 8'h10;
  localparam logic [7:0] ILR_IDX_ENTRY_HIGH_BASE = 8'h11;
  localparam logic [7:0] ILR_IDX_ENTRY_LAST = 8'h4f;
  localparam logic [7:0] ILR_IDX_EOI = 8'h60;

  // low word field positions
  localparam int unsigned ILR_VEC_LSB = 0;
  localparam int unsigned ILR_VEC_MSB = 7;
  localparam int unsigned ILR_DMODE_LSB = 8;
  localparam int unsigned ILR_DMODE_MSB = 10;
  localparam int unsigned ILR_DESTMODE_BIT = 11;
  localparam int unsigned ILR_STATUS_BIT = 12;
  localparam int unsigned ILR_POL_BIT = 13;
  localparam int unsigned ILR_REMOTE_BIT = 14;
  localparam int unsigned ILR_TRIG_BIT = 15;
  localparam int unsigned ILR_MASK_BIT = 16;

  // high word field position (entry bits 63:56)
  localparam int unsigned ILR_DEST_LSB = 24;
  localparam int unsigned ILR_DEST_MSB = 31;

  // destination id position in the message address
  localparam int unsigned ILR_MSG_DEST_LSB = 12;
  localparam int unsigned ILR_MSG_DEST_MSB = 19;

  // delivery mode codes
  localparam logic [2:0] ILR_DM_CODE_FIXED = 3'h0;
  localparam logic [2:0] ILR_DM_CODE_LOWEST = 3'h1;
  localparam logic [2:0] ILR_DM_CODE_MGMT = 3'h2;
  localparam logic [2:0] ILR_DM_CODE_NMI = 3'h4;
  localparam logic [2:0] ILR_DM_CODE_INIT = 3'h5;
  localparam logic [2:0] ILR_DM_CODE_EXTCTL = 3'h7;

  typedef enum logic [2:0] {
    ILR_FIXED_DELIVERY,
    ILR_LOWEST_PRIORITY_DELIVERY,
    ILR_MANAGEMENT_INTERRUPT_DELIVERY,
    ILR_NMI_DELIVERY,
    ILR_INIT_DELIVERY,
    ILR_EXTERNAL_CONTROLLER_DELIVERY,
    ILR_RESERVED_DELIVERY
  } ilr_dlv_type;

  typedef struct packed {
    logic [7:0] dest_id;
    logic mask;
    logic trigger_level;
    logic remote_pending_flag;
    logic polarity_low;
    logic delivery_pending;
    logic dest_logical;
    logic [2:0] dmode;
    logic [7:0] vector;
  } ilr_entry_type;

  // value of every entry after reset: input blocked
  localparam ilr_entry_type ILR_ENTRY_RST = '{
    dest_id: 8'h00,
    mask: 1'b1,
    trigger_level: 1'b0,
    remote_pending_flag: 1'b0,
    polarity_low: 1'b0,
    delivery_pending: 1'b0,
    dest_logical: 1'b0,
    dmode: 3'h0,
    vector: 8'h00
  };

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] wdata;
  } ilr_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } ilr_eoi_type;

  typedef struct packed {
    logic [7:0] vector;
    ilr_dlv_type dlv;
    logic dest_logical;
    logic trigger_level;
    logic [31:0] addr;
  } ilr_msg_type;

endpackage

// ---- hw/ilr_route_top.sv ----
// redirection entries, message issue and legacy southbridge routing
// Notes on behaviour
// - one disable bit per mapped interrupt
// - 32 mode: line k ORs k,k+8,k+16,k+24
// - 24 mode: line k ORs k,k+8,k+16
// - disabled interrupts never produce a message
// - routing on: disabled interrupts reach southbridge
// - routing off: southbridge lines held low
// - entry n low word at index 0x10+2n
// - vector bits 7:0 go into message
// - delivery mode bits 10:8 decoded
// - bit 11 physical or logical destination
// - bit 12 read-only send pending status
// - bit 13 polarity, keep at zero
// - level: remote flag set on delivery, eoi clears
// - end of interrupt matched by vector
// - bit 15 edge or level trigger
// - mask bit 16 resets to one
// - mode input selects 32 or 24 entries
// - destination bits 63:56 to address 19:12
`timescale 1ns/1ps
module ilr_route_top (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // feature controls
  input wire logic i_mode32,
  input wire logic i_sb_route_en,
  // mapped interrupt levels
  input wire logic [31:0] i_irq,
  // register port
  input wire ilr_pkg::ilr_reg_req_type i_reg,
  output logic [31:0] o_reg_rdata,
  // end of interrupt cycles
  input wire ilr_pkg::ilr_eoi_type i_eoi,
  // interrupt messages
  output logic o_msg_valid,
  input wire logic i_msg_ready,
  output ilr_pkg::ilr_msg_type o_msg,
  // southbridge lines
  output logic [7:0] o_sb_line
);

  typedef struct packed {
    ilr_pkg::ilr_entry_type [31:0] ent;
    logic [31:0] lvl_prev;
    logic msg_valid;
    logic [4:0] msg_idx;
    ilr_pkg::ilr_msg_type msg;
    logic [31:0] rdata;
  } ilr_state_type;

  localparam ilr_state_type ST_RST = '{
    ent: {32{ilr_pkg::ILR_ENTRY_RST}},
    lvl_prev: 32'h0000_0000,
    msg_valid: 1'b0,
    msg_idx: 5'h00,
    msg: '0,
    rdata: 32'h0000_0000
  };

  ilr_state_type st_r;
  ilr_state_type st_nxt;
  logic [31:0] disable_bits;

  // entry number behind a register index
  function automatic logic [4:0] entry_of(input logic [7:0] idx);
    logic [7:0] rel;
    rel = idx - ilr_pkg::ILR_IDX_ENTRY_LOW_BASE;
    return rel[5:1];
  endfunction

  // index lies in the entry window
  function automatic logic in_table(input logic [7:0] idx);
    return (idx >= ilr_pkg::ILR_IDX_ENTRY_LOW_BASE) && (idx <= ilr_pkg::ILR_IDX_ENTRY_LAST);
  endfunction

  // low word index of an entry
  function automatic logic is_low(input logic [7:0] idx);
    return in_table(idx) && (idx[0] == ilr_pkg::ILR_IDX_ENTRY_LOW_BASE[0]);
  endfunction

  // high word index of an entry
  function automatic logic is_high(input logic [7:0] idx);
    return in_table(idx) && (idx[0] == ilr_pkg::ILR_IDX_ENTRY_HIGH_BASE[0]);
  endfunction

  // entries in use for the mode
  function automatic logic [31:0] active_set(input logic mode32);
    logic [31:0] s;
    s = 32'hffff_ffff;
    if (!mode32) begin
      s = 32'h00ff_ffff;
    end
    return s;
  endfunction

  // delivery mode decode
  function automatic ilr_pkg::ilr_dlv_type decode_dlv(input logic [2:0] code);
    ilr_pkg::ilr_dlv_type d;
    unique case (code)
      ilr_pkg::ILR_DM_CODE_FIXED: d = ilr_pkg::ILR_FIXED_DELIVERY;
      ilr_pkg::ILR_DM_CODE_LOWEST: d = ilr_pkg::ILR_LOWEST_PRIORITY_DELIVERY;
      ilr_pkg::ILR_DM_CODE_MGMT: d = ilr_pkg::ILR_MANAGEMENT_INTERRUPT_DELIVERY;
      ilr_pkg::ILR_DM_CODE_NMI: d = ilr_pkg::ILR_NMI_DELIVERY;
      ilr_pkg::ILR_DM_CODE_INIT: d = ilr_pkg::ILR_INIT_DELIVERY;
      ilr_pkg::ILR_DM_CODE_EXTCTL: d = ilr_pkg::ILR_EXTERNAL_CONTROLLER_DELIVERY;
      default: d = ilr_pkg::ILR_RESERVED_DELIVERY;
    endcase
    return d;
  endfunction

  // low word image of an entry
  function automatic logic [31:0] low_word(input ilr_pkg::ilr_entry_type e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ilr_pkg::ILR_VEC_MSB:ilr_pkg::ILR_VEC_LSB] = e.vector;
    w[ilr_pkg::ILR_DMODE_MSB:ilr_pkg::ILR_DMODE_LSB] = e.dmode;
    w[ilr_pkg::ILR_DESTMODE_BIT] = e.dest_logical;
    w[ilr_pkg::ILR_STATUS_BIT] = e.delivery_pending;
    w[ilr_pkg::ILR_POL_BIT] = e.polarity_low;
    w[ilr_pkg::ILR_REMOTE_BIT] = e.remote_pending_flag;
    w[ilr_pkg::ILR_TRIG_BIT] = e.trigger_level;
    w[ilr_pkg::ILR_MASK_BIT] = e.mask;
    return w;
  endfunction

  // high word image of an entry
  function automatic logic [31:0] high_word(input ilr_pkg::ilr_entry_type e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ilr_pkg::ILR_DEST_MSB:ilr_pkg::ILR_DEST_LSB] = e.dest_id;
    return w;
  endfunction

  // software write of a low word, status bits untouched
  function automatic ilr_pkg::ilr_entry_type write_low(
    input ilr_pkg::ilr_entry_type e,
    input logic [31:0] w
  );
    ilr_pkg::ilr_entry_type r;
    r = e;
    r.vector = w[ilr_pkg::ILR_VEC_MSB:ilr_pkg::ILR_VEC_LSB];
    r.dmode = w[ilr_pkg::ILR_DMODE_MSB:ilr_pkg::ILR_DMODE_LSB];
    r.dest_logical = w[ilr_pkg::ILR_DESTMODE_BIT];
    r.polarity_low = w[ilr_pkg::ILR_POL_BIT];
    r.trigger_level = w[ilr_pkg::ILR_TRIG_BIT];
    r.mask = w[ilr_pkg::ILR_MASK_BIT];
    return r;
  endfunction

  // message built from an entry
  function automatic ilr_pkg::ilr_msg_type build_msg(input ilr_pkg::ilr_entry_type e);
    ilr_pkg::ilr_msg_type m;
    m.vector = e.vector;
    m.dlv = decode_dlv(e.dmode);
    m.dest_logical = e.dest_logical;
    m.trigger_level = e.trigger_level;
    m.addr = 32'h0000_0000;
    m.addr[ilr_pkg::ILR_MSG_DEST_MSB:ilr_pkg::ILR_MSG_DEST_LSB] = e.dest_id;
    return m;
  endfunction

  // register read data
  function automatic logic [31:0] read_word(
    input ilr_state_type s,
    input logic [7:0] idx
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    if (is_low(idx)) begin
      w = low_word(s.ent[entry_of(idx)]);
    end else if (is_high(idx)) begin
      w = high_word(s.ent[entry_of(idx)]);
    end
    return w;
  endfunction

  // end of interrupt vector match for one entry
  function automatic logic vector_hit(
    input ilr_pkg::ilr_entry_type e,
    input logic [7:0] v
  );
    return e.vector == v;
  endfunction

  // request raised by one mapped line for its entry
  function automatic logic wants_send(
    input ilr_pkg::ilr_entry_type e,
    input logic level,
    input logic rose
  );
    logic w;
    w = 1'b0;
    if (!e.mask) begin
      if (e.trigger_level) begin
        w = level && !e.remote_pending_flag;
      end else begin
        w = rose;
      end
    end
    return w;
  endfunction

  // entry state once its message is taken
  function automatic ilr_pkg::ilr_entry_type retire(
    input ilr_pkg::ilr_entry_type e,
    input logic was_level
  );
    ilr_pkg::ilr_entry_type r;
    r = e;
    r.delivery_pending = 1'b0;
    if (was_level) begin
      r.remote_pending_flag = 1'b1;
    end
    return r;
  endfunction

  // lowest numbered member of a set, found flag on top
  function automatic logic [5:0] lowest_of(input logic [31:0] s);
    logic [5:0] r;
    r = 6'h00;
    for (int n = 31; n >= 0; n--) begin
      if (s[n]) begin
        r = {1'b1, n[4:0]};
      end
    end
    return r;
  endfunction

  // register request split into its targets
  typedef struct packed {
    logic low_wr;
    logic high_wr;
    logic eoi_wr;
    logic [4:0] ent;
  } ilr_reg_dec_type;

  // register request decode
  function automatic ilr_reg_dec_type decode_req(input ilr_pkg::ilr_reg_req_type q);
    ilr_reg_dec_type d;
    d.low_wr = q.wr && is_low(q.idx);
    d.high_wr = q.wr && is_high(q.idx);
    d.eoi_wr = q.wr && (q.idx == ilr_pkg::ILR_IDX_EOI);
    d.ent = entry_of(q.idx);
    return d;
  endfunction

  always_comb begin
    logic [31:0] act;
    logic [31:0] rise;
    logic [31:0] ready_set;
    logic [5:0] win;
    ilr_reg_dec_type dec;
    st_nxt = st_r;
    act = active_set(i_mode32);
    rise = i_irq & ~st_r.lvl_prev;
    ready_set = 32'h0000_0000;
    win = 6'h00;
    dec = decode_req(i_reg);
    st_nxt.lvl_prev = i_irq;

    // register read answer, one cycle after the request
    if (i_reg.rd) begin
      st_nxt.rdata = read_word(st_r, i_reg.idx);
    end

    // register writes
    if (dec.low_wr) begin
      st_nxt.ent[dec.ent] = write_low(st_r.ent[dec.ent], i_reg.wdata);
    end
    if (dec.high_wr) begin
      st_nxt.ent[dec.ent].dest_id =
        i_reg.wdata[ilr_pkg::ILR_DEST_MSB:ilr_pkg::ILR_DEST_LSB];
    end

    // end of interrupt clears matching remote flags
    for (int n = 0; n < 32; n++) begin
      if (i_eoi.valid && vector_hit(st_r.ent[n], i_eoi.vector)) begin
        st_nxt.ent[n].remote_pending_flag = 1'b0;
      end
      if (dec.eoi_wr && vector_hit(st_r.ent[n], i_reg.wdata[ilr_pkg::ILR_VEC_MSB:0])) begin
        st_nxt.ent[n].remote_pending_flag = 1'b0;
      end
    end

    // accepted message retires its pending state
    if (st_r.msg_valid && i_msg_ready) begin
      st_nxt.msg_valid = 1'b0;
      st_nxt.ent[st_r.msg_idx] =
        retire(st_nxt.ent[st_r.msg_idx], st_r.ent[st_r.msg_idx].trigger_level);
    end else if (st_r.msg_valid && st_nxt.ent[st_r.msg_idx].mask) begin
      st_nxt.msg_valid = 1'b0;
    end

    // new requests from the mapped lines
    for (int n = 0; n < 32; n++) begin
      if (act[n] && wants_send(st_nxt.ent[n], i_irq[n], rise[n])) begin
        st_nxt.ent[n].delivery_pending = 1'b1;
      end
    end

    // candidates for the next message: pending, enabled, in use
    for (int n = 0; n < 32; n++) begin
      ready_set[n] = act[n] && st_nxt.ent[n].delivery_pending && !st_nxt.ent[n].mask;
    end
    if (st_r.msg_valid && !i_msg_ready) begin
      ready_set[st_r.msg_idx] = 1'b0;
    end

    // lowest numbered candidate wins
    win = lowest_of(ready_set);
    if (!st_nxt.msg_valid && win[5]) begin
      st_nxt.msg_valid = 1'b1;
      st_nxt.msg_idx = win[4:0];
      st_nxt.msg = build_msg(st_nxt.ent[win[4:0]]);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // disable bits feed the legacy path
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      disable_bits[n] = st_r.ent[n].mask;
    end
  end

  ilr_sb_combine u_sb_combine (
    .i_irq(i_irq),
    .i_disable(disable_bits),
    .i_mode32(i_mode32),
    .i_route_en(i_sb_route_en),
    .o_sb_line(o_sb_line)
  );

  assign o_msg_valid = st_r.msg_valid;
  assign o_msg = st_r.msg;
  assign o_reg_rdata = st_r.rdata;

endmodule

// ---- hw/ilr_sb_combine.sv ----
// folds disabled mapped interrupts onto the eight southbridge lines
`timescale 1ns/1ps
module ilr_sb_combine (
  // mapped interrupt levels and their disable bits
  input wire logic [31:0] i_irq,
  input wire logic [31:0] i_disable,
  // mode and routing option
  input wire logic i_mode32,
  input wire logic i_route_en,
  // southbridge lines
  output logic [7:0] o_sb_line
);

  logic [31:0] routed;
  logic [7:0] fold;

  always_comb begin
    routed = i_irq & i_disable;
    fold = routed[7:0] | routed[15:8] | routed[23:16];
    if (i_mode32) begin
      fold = fold | routed[31:24];
    end
    if (i_route_en) begin
      o_sb_line = fold;
    end else begin
      o_sb_line = 8'h00;
    end
  end

endmodule

// ---- test/ilr_proc_model.sv ----
// processor side model: takes messages, optionally after a stall
`timescale 1ns/1ps
module ilr_proc_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // message channel
  input wire logic i_msg_valid,
  input wire ilr_pkg::ilr_msg_type i_msg,
  output logic o_ready,
  // stall length and capture
  input wire logic [3:0] i_stall,
  output ilr_pkg::ilr_msg_type o_last,
  output logic [7:0] o_taken
);
  logic [3:0] wait_cnt;
  always @(negedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (i_msg_valid && !o_ready && wait_cnt >= i_stall) begin
      o_ready <= 1'b1;
    end else if (i_msg_valid && !o_ready) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else begin
      o_ready <= 1'b0;
      wait_cnt <= 4'h0;
    end
  end
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_last <= '0;
      o_taken <= 8'h00;
    end else if (i_msg_valid && o_ready) begin
      o_last <= i_msg;
      o_taken <= o_taken + 8'h01;
    end
  end
endmodule

// ---- test/ilr_route_properties.sv ----
// port assertions for the legacy route block
`timescale 1ns/1ps
module ilr_route_properties (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // inputs
  input wire logic i_mode32,
  input wire logic i_sb_route_en,
  input wire logic [31:0] i_irq,
  input wire ilr_pkg::ilr_reg_req_type i_reg,
  input wire logic i_msg_ready,
  // outputs
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_msg_valid,
  input wire ilr_pkg::ilr_msg_type o_msg,
  input wire logic [7:0] o_sb_line
);
  logic [7:0] fold;
  assign fold = i_irq[7:0] | i_irq[15:8] | i_irq[23:16] | (i_mode32 ? i_irq[31:24] : 8'h00);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_stall;
    o_msg_valid && !i_msg_ready && !i_reg.wr && !$past(i_reg.wr);
  endsequence
  sequence s_rd_low;
    i_reg.rd && i_reg.idx inside {[8'h10:8'h4f]} && !i_reg.idx[0];
  endsequence
  sequence s_rd_high;
    i_reg.rd && i_reg.idx inside {[8'h10:8'h4f]} && i_reg.idx[0];
  endsequence
  AST_SB_OFF: assert property (!i_sb_route_en |-> o_sb_line == 8'h00)
    else $error("sb lines active with routing off");
  AST_SB_FOLD: assert property (i_sb_route_en |-> (o_sb_line & ~fold) == 8'h00)
    else $error("sb line without a folded input");
  AST_SB_IDLE: assert property (i_irq == 32'h0 |-> o_sb_line == 8'h00)
    else $error("sb line without any input");
  AST_MSG_HOLD: assert property (s_stall |=> o_msg_valid && $stable(o_msg))
    else $error("offered message changed");
  AST_MSG_ADDR: assert property (o_msg_valid |-> o_msg.addr[11:0] == 12'h000 && o_msg.addr[31:20] == 12'h000)
    else $error("message address bits outside dest");
  AST_RD_HOLD: assert property (!i_reg.rd |=> $stable(o_reg_rdata))
    else $error("read data changed without read");
  AST_LOW_RSVD: assert property (s_rd_low |=> o_reg_rdata[31:17] == 15'h0000)
    else $error("reserved low bits nonzero");
  AST_HIGH_RSVD: assert property (s_rd_high |=> o_reg_rdata[23:0] == 24'h000000)
    else $error("reserved high bits nonzero");
  AST_UNMAPPED: assert property (i_reg.rd && (i_reg.idx < 8'h10 || i_reg.idx > 8'h60) |=> o_reg_rdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule
bind ilr_route_top ilr_route_properties i_props (.i_clk_sys, .i_arst_n, .i_mode32,
  .i_sb_route_en, .i_irq, .i_reg, .i_msg_ready, .o_reg_rdata, .o_msg_valid, .o_msg, .o_sb_line);

// ---- test/tb.sv ----
// self-checking bench for the legacy route block
`timescale 1ns/1ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_mode32 = 1'b1;
  logic i_sb_route_en = 1'b0;
  logic [31:0] i_irq = 32'h0;
  ilr_pkg::ilr_reg_req_type i_reg = '0;
  ilr_pkg::ilr_eoi_type i_eoi = '0;
  logic [31:0] o_reg_rdata;
  logic o_msg_valid;
  logic i_msg_ready;
  ilr_pkg::ilr_msg_type o_msg;
  ilr_pkg::ilr_msg_type last;
  logic [7:0] o_sb_line;
  logic [7:0] taken;
  logic [7:0] n0;
  logic [3:0] stall = 4'h0;
  logic [7:0] exp_line;
  logic [7:0] rot_exp;
  int mismatches = 0;
  int checks_done = 0;
  logic [2:0] dlv_exp [8] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h4, 3'h6, 3'h5};
  initial forever #4 i_clk_sys = ~i_clk_sys;
  ilr_route_top i_dut (.i_clk_sys, .i_arst_n, .i_mode32, .i_sb_route_en, .i_irq, .i_reg,
    .o_reg_rdata, .i_eoi, .o_msg_valid, .i_msg_ready, .o_msg, .o_sb_line);
  ilr_proc_model i_model (.i_clk_sys, .i_arst_n, .i_msg_valid(o_msg_valid), .i_msg(o_msg),
    .o_ready(i_msg_ready), .i_stall(stall), .o_last(last), .o_taken(taken));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // far side rotation of a secondary chip's lines
  function automatic logic [7:0] sec_rotate(input logic [7:0] s);
    return {s[7:4], s[2:0], s[3]};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(negedge i_clk_sys);
    i_reg = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
    @(negedge i_clk_sys);
    i_reg.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    @(negedge i_clk_sys);
    i_reg = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 32'h0};
    @(negedge i_clk_sys);
    i_reg.rd = 1'b0;
    chk(o_reg_rdata, exp);
  endtask
  task automatic eoi(input logic [7:0] v);
    @(negedge i_clk_sys);
    i_eoi = '{valid: 1'b1, vector: v};
    @(negedge i_clk_sys);
    i_eoi.valid = 1'b0;
  endtask
  task automatic take(input logic [7:0] n);
    for (int c = 0; c < 40 && taken !== n; c++) @(negedge i_clk_sys);
    chk({24'h0, taken}, {24'h0, n});
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_arst_n = 1'b1;
    for (int n = 0; n < 32; n++) rd(8'h10 + 8'(2 * n), 32'h0001_0000);
    rd(8'h11, 32'h0);
    rd(8'h05, 32'h0);
    $display("reset test done");
    wr(8'h12, 32'hfffe_dfff);
    rd(8'h12, 32'h0000_8fff);
    wr(8'h13, 32'h5aff_ffff);
    rd(8'h13, 32'h5a00_0000);
    for (int m = 0; m < 8; m++) begin
      wr(8'h12, {20'h0, m[0], m[2:0], 8'h40 + 8'(m)});
      i_irq[1] = 1'b1;
      take(8'(m + 1));
      i_irq[1] = 1'b0;
      chk({24'h0, last.vector}, {24'h0, 8'h40 + 8'(m)});
      chk({29'h0, last.dlv}, {29'h0, dlv_exp[m]});
      chk({31'h0, last.dest_logical}, {31'h0, m[0]});
      chk(last.addr, 32'h0005_a000);
      chk({31'h0, last.trigger_level}, 32'h0);
      rd(8'h12, {20'h0, m[0], m[2:0], 8'h40 + 8'(m)});
    end
    stall = 4'h8;
    i_irq[1] = 1'b1;
    rd(8'h12, 32'h0000_1f47);
    take(8'h09);
    stall = 4'h0;
    i_irq = 32'h0000_0004;
    wr(8'h42, 32'h0000_0020);
    i_mode32 = 1'b0;
    i_irq[25] = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    chk({24'h0, taken}, 32'h9);
    chk({24'h0, o_sb_line}, 32'h0);
    $display("message test done");
    i_sb_route_en = 1'b1;
    for (int md = 0; md < 2; md++) begin
      for (int n = 0; n < 32; n++) begin
        @(negedge i_clk_sys);
        i_mode32 = md[0];
        i_irq = 32'h1 << n;
        #1;
        exp_line = (n != 1 && n != 25 && (n < 24 || md == 1)) ? 8'h01 << (n % 8) : 8'h00;
        rot_exp = (exp_line == 8'h00) ? 8'h00 : 8'h01 << ((n % 8 < 4) ? (n + 1) % 4 : n % 8);
        chk({24'h0, o_sb_line}, {24'h0, exp_line});
        chk({24'h0, sec_rotate(o_sb_line)}, {24'h0, rot_exp});
      end
    end
    i_sb_route_en = 1'b0;
    i_irq = 32'h0;
    $display("southbridge test done");
    repeat (5) @(negedge i_clk_sys);
    n0 = taken;
    wr(8'h18, 32'h0000_8077);
    i_irq[4] = 1'b1;
    take(n0 + 8'h01);
    chk({24'h0, last.vector}, 32'h77);
    chk({31'h0, last.trigger_level}, 32'h1);
    repeat (5) @(negedge i_clk_sys);
    chk({24'h0, taken}, {24'h0, n0 + 8'h01});
    rd(8'h18, 32'h0000_c077);
    i_irq[4] = 1'b0;
    eoi(8'h76);
    rd(8'h18, 32'h0000_c077);
    eoi(8'h77);
    rd(8'h18, 32'h0000_8077);
    i_irq[4] = 1'b1;
    take(n0 + 8'h02);
    i_irq[4] = 1'b0;
    wr(8'h60, 32'h0000_0077);
    rd(8'h18, 32'h0000_8077);
    $display("level test done");
    finish_test;
  end
endmodule
